// >>> hw/touch_key_pkg.sv
// Package: register map, field positions and shared types of the touch-key scanner
package touch_key_pkg;

   // --------------------------------------------------------------
   // Common register byte offsets
   // --------------------------------------------------------------
   localparam logic [11:0] OFS_PRELOAD = 12'h000;
   localparam logic [11:0] OFS_CTRL0 = 12'h004;
   localparam logic [11:0] OFS_CTRL1 = 12'h008;
   localparam logic [11:0] OFS_FUNC_LO = 12'h00c;
   localparam logic [11:0] OFS_FUNC_HI = 12'h010;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h014;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h018;
   localparam logic [11:0] OFS_PIN_SELECT = 12'h01c;

   // --------------------------------------------------------------
   // Per-module register block: base + index * stride + offset
   // --------------------------------------------------------------
   localparam logic [11:0] MOD_BASE = 12'h040;
   localparam int MOD_STRIDE_SHIFT = 5;
   localparam logic [4:0] MOFS_FREQ_LO = 5'h00;
   localparam logic [4:0] MOFS_FREQ_HI = 5'h04;
   localparam logic [4:0] MOFS_REF_LO = 5'h08;
   localparam logic [4:0] MOFS_REF_HI = 5'h0c;
   localparam logic [4:0] MOFS_CTRL0 = 5'h10;
   localparam logic [4:0] MOFS_CTRL1 = 5'h14;
   localparam logic [4:0] MOFS_CTRL2 = 5'h18;

   // --------------------------------------------------------------
   // Field positions
   // --------------------------------------------------------------
   localparam int C0_RAMC = 7;
   localparam int C0_SLOT_OVF = 6;
   localparam int C0_START = 5;
   localparam int C0_CF_OVF = 4;
   localparam int C0_FUNC_OVF = 3;
   localparam int C0_MODE = 1;
   localparam int C0_BUSY = 0;
   localparam logic [7:0] C0_SW_MASK = 8'hfa;
   localparam int MC1_REF_EN = 5;
   localparam int MC1_KEY_EN = 4;
   localparam logic [1:0] REF_HI_MASK = 2'h3;
   localparam int IRQ_SLOT = 0;
   localparam int IRQ_CF = 1;
   localparam int IRQ_FUNC = 2;
   localparam int IRQ_BITS = 3;

   // --------------------------------------------------------------
   // Reset values and counter limits
   // --------------------------------------------------------------
   localparam logic [7:0] PRELOAD_RESET = 8'h00;
   localparam logic [15:0] CNT16_MAX = 16'hffff;

   typedef struct packed {
      logic [15:0] freqCnt;
      logic [9:0] refCap;
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
   } module_regs_t;

endpackage : touch_key_pkg

// >>> hw/touch_key_scan.sv
// Touch-key time-slot scanner: per-module frequency counters, time-slot timer, APB registers
`timescale 1ns/1ps
module touch_key_scan
   import touch_key_pkg::*;
#(
   parameter int NUM_MODULES = 4,
   parameter int DIV_BITS = 5,
   parameter int SLOT_BITS = 8
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Key and reference oscillators, pin function
   input wire logic [NUM_MODULES*4-1:0] keyOsc,
   input wire logic [NUM_MODULES-1:0] refOsc,
   output logic [NUM_MODULES*4-1:0] keyOscEn,
   output logic [NUM_MODULES-1:0] refOscEn,
   output logic [NUM_MODULES*4-1:0] pinTouchSel,
   // Interrupt
   output logic irq
);

   localparam int NUM_KEYS = NUM_MODULES * 4;
   localparam logic [DIV_BITS-1:0] DIV_MAX = '1;
   localparam logic [SLOT_BITS-1:0] SLOT_MAX = '1;

   // --------------------------------------------------------------
   // Parameter checks
   // --------------------------------------------------------------
   if (NUM_MODULES < 1 || NUM_MODULES > 8) begin : g_chk_mod
      $error("NUM_MODULES must be 1 to 8");
   end
   if (DIV_BITS != 5 || SLOT_BITS != 8) begin : g_chk_timer
      $error("Timer is built for a 5-bit divider and 8-bit slot counter");
   end

   typedef struct packed {
      module_regs_t [NUM_MODULES-1:0] mods;
      logic [7:0] preload;
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [15:0] funcCnt;
      logic [DIV_BITS-1:0] divCnt;
      logic [SLOT_BITS-1:0] slotCnt;
      logic running;
      logic [IRQ_BITS-1:0] irqSt;
      logic [IRQ_BITS-1:0] irqMask;
      logic [NUM_KEYS-1:0] pinSel;
      logic [NUM_KEYS-1:0] keyS1;
      logic [NUM_KEYS-1:0] keyS2;
      logic [NUM_KEYS-1:0] keyS3;
      logic [NUM_MODULES-1:0] refS1;
      logic [NUM_MODULES-1:0] refS2;
      logic [NUM_KEYS-1:0] keyOscEn;
      logic [NUM_MODULES-1:0] refOscEn;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } state_t;

   typedef struct packed {
      logic hit;
      logic isMod;
      logic [2:0] idx;
      logic [4:0] sub;
   } decode_t;

   state_t s;
   state_t next_s;
   logic rstMeta;
   logic rstSync;

   // --------------------------------------------------------------
   // Reset release
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // --------------------------------------------------------------
   // Address decode, shared by reads and writes
   // --------------------------------------------------------------
   function automatic decode_t decodeAddr(input logic [11:0] a);
      decode_t d;
      logic [11:0] rel;
      d = '0;
      rel = a - MOD_BASE;
      if (a[1:0] != 2'h0) begin
         d.hit = 1'b0;
      end else if (a < MOD_BASE) begin
         d.sub = a[4:0];
         d.hit = (a <= OFS_PIN_SELECT);
      end else begin
         d.isMod = 1'b1;
         d.idx = rel[MOD_STRIDE_SHIFT+2:MOD_STRIDE_SHIFT];
         d.sub = rel[4:0];
         d.hit = (rel[11:MOD_STRIDE_SHIFT] < 7'(NUM_MODULES)) && (d.sub <= MOFS_CTRL2);
      end
      return d;
   endfunction : decodeAddr

   function automatic logic [31:0] readReg(input state_t st, input decode_t d);
      logic [31:0] v;
      module_regs_t mr;
      v = '0;
      mr = st.mods[d.idx];
      if (d.isMod) begin
         case (d.sub)
            MOFS_FREQ_LO: v[7:0] = mr.freqCnt[7:0];
            MOFS_FREQ_HI: v[7:0] = mr.freqCnt[15:8];
            MOFS_REF_LO: v[7:0] = mr.refCap[7:0];
            MOFS_REF_HI: v[1:0] = mr.refCap[9:8];
            MOFS_CTRL0: v[7:0] = mr.ctrl0;
            MOFS_CTRL1: v[7:0] = mr.ctrl1;
            MOFS_CTRL2: v[7:0] = mr.ctrl2;
            default: v = '0;
         endcase
      end else begin
         case ({7'h00, d.sub})
            OFS_PRELOAD: v[7:0] = st.preload;
            OFS_CTRL0: v[7:0] = st.ctrl0;
            OFS_CTRL1: v[7:0] = st.ctrl1;
            OFS_FUNC_LO: v[7:0] = st.funcCnt[7:0];
            OFS_FUNC_HI: v[7:0] = st.funcCnt[15:8];
            OFS_IRQ_STATUS: v[IRQ_BITS-1:0] = st.irqSt;
            OFS_IRQ_MASK: v[IRQ_BITS-1:0] = st.irqMask;
            OFS_PIN_SELECT: v[NUM_KEYS-1:0] = st.pinSel;
            default: v = '0;
         endcase
      end
      return v;
   endfunction : readReg

   // --------------------------------------------------------------
   // Next-state logic
   // --------------------------------------------------------------
   always_comb begin
      decode_t d;
      logic wr;
      logic startRise;
      logic divWrap;
      logic slotWrap;
      logic [1:0] keySel;
      logic [NUM_KEYS-1:0] keyRise;
      d = decodeAddr(paddr);
      wr = psel && penable && pwrite && s.pready;
      startRise = 1'b0;
      keySel = 2'h0;
      divWrap = 1'b0;
      slotWrap = 1'b0;
      keyRise = '0;
      next_s = s;
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;

      // Oscillator inputs cross in through two flops, third flop for key edges
      next_s.keyS1 = keyOsc;
      next_s.keyS2 = s.keyS1;
      next_s.keyS3 = s.keyS2;
      next_s.refS1 = refOsc;
      next_s.refS2 = s.refS1;
      keyRise = s.keyS2 & ~s.keyS3;

      // APB answers one cycle after setup
      if (psel && !penable) begin
         next_s.pready = 1'b1;
         next_s.pslverr = !d.hit;
         next_s.prdata = (d.hit && !pwrite) ? readReg(s, d) : '0;
      end

      // Software writes
      if (wr && d.hit) begin
         if (d.isMod) begin
            case (d.sub)
               MOFS_REF_LO: next_s.mods[d.idx].refCap[7:0] = pwdata[7:0];
               MOFS_REF_HI: next_s.mods[d.idx].refCap[9:8] = pwdata[1:0] & REF_HI_MASK;
               MOFS_CTRL0: next_s.mods[d.idx].ctrl0 = pwdata[7:0];
               MOFS_CTRL1: next_s.mods[d.idx].ctrl1 = pwdata[7:0];
               MOFS_CTRL2: next_s.mods[d.idx].ctrl2 = pwdata[7:0];
               default: next_s.mods[d.idx].ctrl2 = s.mods[d.idx].ctrl2;
            endcase
         end else begin
            case ({7'h00, d.sub})
               OFS_PRELOAD: next_s.preload = pwdata[7:0];
               OFS_CTRL0: begin
                  // Software setting the overflow flag leaves the interrupt alone
                  next_s.ctrl0 = (pwdata[7:0] & C0_SW_MASK) | (s.ctrl0 & ~C0_SW_MASK);
                  startRise = pwdata[C0_START] && !s.ctrl0[C0_START];
               end
               OFS_CTRL1: next_s.ctrl1 = pwdata[7:0];
               OFS_IRQ_STATUS: next_s.irqSt = s.irqSt & ~pwdata[IRQ_BITS-1:0];
               OFS_IRQ_MASK: next_s.irqMask = pwdata[IRQ_BITS-1:0];
               OFS_PIN_SELECT: next_s.pinSel = pwdata[NUM_KEYS-1:0];
               default: next_s.ctrl1 = next_s.ctrl1;
            endcase
         end
      end

      // Time-slot timer and counters
      divWrap = s.running && (s.divCnt == DIV_MAX);
      slotWrap = divWrap && (s.slotCnt == SLOT_MAX);
      if (!s.ctrl0[C0_START]) begin
         // Slot counter keeps its value while stopped
         next_s.divCnt = '0;
         next_s.funcCnt = '0;
         next_s.running = 1'b0;
         for (int m = 0; m < NUM_MODULES; m++) begin
            next_s.mods[m].freqCnt = '0;
         end
      end else if (s.running) begin
         next_s.divCnt = s.divCnt + 1'b1;
         next_s.funcCnt = s.funcCnt + 1'b1;
         if (s.funcCnt == CNT16_MAX) begin
            next_s.ctrl0[C0_FUNC_OVF] = 1'b1;
            next_s.irqSt[IRQ_FUNC] = 1'b1;
         end
         if (divWrap) begin
            next_s.slotCnt = s.slotCnt + 1'b1;
         end
         if (slotWrap) begin
            // Slot overflow ends the scan: flags up, everything halts
            next_s.running = 1'b0;
            next_s.ctrl0[C0_SLOT_OVF] = 1'b1;
            next_s.irqSt[IRQ_SLOT] = 1'b1;
         end
         for (int m = 0; m < NUM_MODULES; m++) begin
            keySel = s.mods[m].ctrl0[1:0];
            if (keyRise[m*4+int'(keySel)]) begin
               next_s.mods[m].freqCnt = s.mods[m].freqCnt + 1'b1;
               if (s.mods[m].freqCnt == CNT16_MAX) begin
                  next_s.ctrl0[C0_CF_OVF] = 1'b1;
                  next_s.irqSt[IRQ_CF] = 1'b1;
               end
            end
         end
      end
      if (startRise) begin
         next_s.running = 1'b1;
         next_s.slotCnt = s.preload;
         next_s.divCnt = '0;
      end
      next_s.ctrl0[C0_BUSY] = next_s.running;

      // Oscillator enables: each key on its own, gated by pin function
      for (int m = 0; m < NUM_MODULES; m++) begin
         next_s.refOscEn[m] = next_s.running && next_s.mods[m].ctrl1[MC1_REF_EN];
         for (int k = 0; k < 4; k++) begin
            next_s.keyOscEn[m*4+k] = next_s.running && next_s.pinSel[m*4+k]
               && next_s.mods[m].ctrl1[MC1_KEY_EN] && next_s.mods[m].ctrl1[k];
         end
      end
      next_s.irq = |(next_s.irqSt & next_s.irqMask);
   end

   // --------------------------------------------------------------
   // State register
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign keyOscEn = s.keyOscEn;
   assign refOscEn = s.refOscEn;
   assign pinTouchSel = s.pinSel;
   assign irq = s.irq;

   // --------------------------------------------------------------
   // Assertions and cover points
   // --------------------------------------------------------------
   logic [13:0] runCycles;
   logic [7:0] startPreload;
   logic startWr;
   logic readRefHi;
   decode_t dq;
   assign dq = decodeAddr(paddr);
   assign startWr = psel && penable && pwrite && s.pready && dq.hit && !dq.isMod
      && ({7'h00, dq.sub} == OFS_CTRL0) && pwdata[C0_START] && !s.ctrl0[C0_START];
   assign readRefHi = s.pready && psel && !pwrite && dq.hit && dq.isMod
      && (dq.sub == MOFS_REF_HI);

   // Window length seen from start to stop, in system clocks
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         runCycles <= '0;
         startPreload <= '0;
      end else if (ce) begin
         if (startWr) begin
            runCycles <= '0;
            startPreload <= s.preload;
         end else if (s.running) begin
            runCycles <= runCycles + 1'b1;
         end
      end
   end

   default clocking cb @(posedge ref_clk iff ce);
   endclocking
   default disable iff (!rstSync);

   a_start_loads: assert property (startWr |=> s.running && s.slotCnt == $past(s.preload))
      else $error("Start did not run with preload");
   a_preload_reset: assert property ($rose(rstSync) |-> s.preload == PRELOAD_RESET)
      else $error("Preload not zero after reset");
   a_unit_period: assert property (s.running && $past(s.running) && s.slotCnt != $past(s.slotCnt)
      |-> $past(s.divCnt) == DIV_MAX)
      else $error("Slot counter stepped outside unit period end");
   a_slot_wrap: assert property (s.running && s.divCnt == DIV_MAX && s.slotCnt == SLOT_MAX
      && s.ctrl0[C0_START] |=> !s.running && s.ctrl0[C0_SLOT_OVF] && s.irqSt[IRQ_SLOT]
      && s.slotCnt == 8'h00)
      else $error("Slot overflow did not stop and flag");
   a_window_len: assert property ($fell(s.running) && s.ctrl0[C0_START]
      |-> runCycles == 14'((256 - int'(startPreload)) * 32))
      else $error("Measurement window length wrong");
   a_stop_clears: assert property (!s.ctrl0[C0_START] && !startWr
      |=> s.divCnt == '0 && s.funcCnt == '0 && s.mods[0].freqCnt == '0
      && $stable(s.slotCnt))
      else $error("Stopped scan left counters uncleared");
   a_func_count: assert property (s.running && s.ctrl0[C0_START] && $past(s.running)
      && $past(s.ctrl0[C0_START]) |-> s.funcCnt == $past(s.funcCnt) + 16'h0001)
      else $error("Function counter did not step");
   a_key_pin: assert property (|keyOscEn |-> (keyOscEn & ~pinTouchSel) == '0 && s.running)
      else $error("Key oscillator on without touch pin function");
   a_ref_high: assert property (readRefHi |-> prdata[31:2] == '0)
      else $error("Reference select high byte has extra bits");
   a_irq_level: assert property (irq == |(s.irqSt & s.irqMask))
      else $error("Interrupt output disagrees with status");

   c_scan_start: cover property (startWr);
   c_scan_done: cover property (s.running ##1 !s.running && s.ctrl0[C0_SLOT_OVF]);
   c_irq_raised: cover property ($rose(irq));
   c_key_count: cover property (s.mods[0].freqCnt != $past(s.mods[0].freqCnt) && s.running);

endmodule : touch_key_scan

// >>> verif/touch_pad_model.sv
// Behavioural touch pads: one oscillator per key, one reference per module
`timescale 1ns/1ps
module touch_pad_model #(
   parameter int NUM_MODULES = 4
) (
   // Clock
   input wire logic ref_clk,
   // Enables from the scanner
   input wire logic [NUM_MODULES*4-1:0] keyOscEn,
   input wire logic [NUM_MODULES-1:0] refOscEn,
   input wire logic [NUM_MODULES*4-1:0] pinTouchSel,
   // Oscillator outputs
   output logic [NUM_MODULES*4-1:0] keyOsc,
   output logic [NUM_MODULES-1:0] refOsc
);
   int cnt [NUM_MODULES*4];

   initial begin
      keyOsc = '0;
      refOsc = '0;
      foreach (cnt[i]) cnt[i] = 0;
   end

   // Key k of each module toggles every k+2 clocks; a stopped pad sits low
   always @(posedge ref_clk) begin
      for (int i = 0; i < NUM_MODULES*4; i++) begin
         if (keyOscEn[i] && pinTouchSel[i]) begin
            cnt[i] = cnt[i] + 1;
            if (cnt[i] >= (i % 4) + 2) begin
               cnt[i] = 0;
               keyOsc[i] <= ~keyOsc[i];
            end
         end else begin
            cnt[i] = 0;
            keyOsc[i] <= 1'b0;
         end
      end
      for (int m = 0; m < NUM_MODULES; m++) begin
         refOsc[m] <= refOscEn[m] ? ~refOsc[m] : 1'b0;
      end
   end
endmodule : touch_pad_model

// >>> verif/tb_touch_key_scan.sv
// Self-checking bench for the touch-key time-slot scanner
`timescale 1ns/1ps
module tb_touch_key_scan;
   import touch_key_pkg::*;
   localparam int LIMIT = 20000;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [15:0] keyOsc;
   logic [3:0] refOsc;
   logic [15:0] keyOscEn;
   logic [3:0] refOscEn;
   logic [15:0] pinTouchSel;
   logic irq;
   int errCount = 0;
   int nCompared = 0;
   int cycles = 0;

   always #12.5 ref_clk = ~ref_clk;

   touch_key_scan DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .keyOsc(keyOsc),
      .refOsc(refOsc), .keyOscEn(keyOscEn), .refOscEn(refOscEn),
      .pinTouchSel(pinTouchSel), .irq(irq));

   touch_pad_model #(.NUM_MODULES(4)) pads (.ref_clk(ref_clk), .keyOscEn(keyOscEn),
      .refOscEn(refOscEn), .pinTouchSel(pinTouchSel), .keyOsc(keyOsc), .refOsc(refOsc));

   // ------------------------------------------------------------
   // Common tasks
   // ------------------------------------------------------------
   task automatic endSim;
      $display("compared %0d, mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : endSim

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      nCompared++;
      if (seen !== exp) begin
         errCount++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // Ends one idle edge after the answer so the next call never re-drives psel at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rd

   function automatic logic [11:0] maddr(input int m, input logic [4:0] o);
      return MOD_BASE + 12'(m << MOD_STRIDE_SHIFT) + 12'(o);
   endfunction : maddr

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_regs;
      logic [31:0] r;
      logic e;
      rd(OFS_PRELOAD, r);
      check(r, 32'h0, "preload reset");
      rd(OFS_CTRL0, r);
      check(r, 32'h0, "control0 reset");
      wr(OFS_PRELOAD, 32'ha5);
      rd(OFS_PRELOAD, r);
      check(r, 32'ha5, "preload readback");
      apb(1'b1, 12'h020, 32'h1, r, e);
      check({31'h0, e}, 32'h1, "unmapped error");
      wr(OFS_FUNC_LO, 32'hff);
      rd(OFS_FUNC_LO, r);
      check(r, 32'h0, "read-only write");
      wr(maddr(0, MOFS_REF_LO), 32'hff);
      wr(maddr(0, MOFS_REF_HI), 32'hff);
      wr(maddr(1, MOFS_REF_LO), 32'h12);
      rd(maddr(0, MOFS_REF_HI), r);
      check(r, 32'h3, "cap select high");
      rd(maddr(0, MOFS_REF_LO), r);
      check(r, 32'hff, "cap select low");
      rd(maddr(1, MOFS_REF_LO), r);
      check(r, 32'h12, "second module");
      wr(OFS_PIN_SELECT, 32'h0f0f);
      check(32'(pinTouchSel), 32'h0f0f, "pin select");
      wr(OFS_PIN_SELECT, 32'hffff);
      check(32'(pinTouchSel), 32'hffff, "pin select");
      $display("test_regs finished");
   endtask : test_regs

   task automatic test_scan(input logic [7:0] pre, input logic msk);
      logic [31:0] r;
      logic [31:0] h;
      int n;
      int win;
      int k;
      n = 0;
      win = (256 - int'(pre)) * 32;
      wr(OFS_PRELOAD, {24'h0, pre});
      wr(OFS_IRQ_MASK, {31'h0, msk});
      wr(maddr(0, MOFS_CTRL0), 32'h2);
      wr(maddr(0, MOFS_CTRL1), 32'h34);
      wr(OFS_CTRL0, 32'h0);
      wr(OFS_CTRL0, 32'h20);
      while (refOscEn[0] !== 1'b1 && n < 10) begin
         n++;
         @(posedge ref_clk);
      end
      n = 0;
      while (refOscEn[0] === 1'b1 && n < 4000) begin
         if (n == 4) check(32'(keyOscEn), 32'h4, "key enables");
         n++;
         @(posedge ref_clk);
      end
      check(32'(n), 32'(win), "window length");
      @(posedge ref_clk);
      check(32'(keyOscEn), 32'h0, "oscillators stopped");
      check({31'h0, irq}, {31'h0, msk}, "irq level");
      rd(OFS_CTRL0, r);
      check(r, 32'h60, "overflow flag");
      rd(OFS_IRQ_STATUS, r);
      check(r, 32'h1, "irq status");
      rd(OFS_FUNC_LO, r);
      rd(OFS_FUNC_HI, h);
      check(r | (h << 8), 32'(win), "function count");
      rd(maddr(0, MOFS_FREQ_LO), r);
      rd(maddr(0, MOFS_FREQ_HI), h);
      k = int'(r | (h << 8));
      check(32'(k >= win / 8 - 2 && k <= win / 8), 32'h1, "key edge count");
      wr(OFS_IRQ_MASK, 32'h1);
      check({31'h0, irq}, 32'h1, "irq unmasked");
      wr(OFS_IRQ_STATUS, 32'h1);
      check({31'h0, irq}, 32'h0, "irq cleared");
      wr(OFS_CTRL0, 32'h0);
      rd(OFS_FUNC_LO, r);
      check(r, 32'h0, "function cleared");
      rd(maddr(0, MOFS_FREQ_LO), r);
      check(r, 32'h0, "module count cleared");
      $display("test_scan finished, preload %h", pre);
   endtask : test_scan

   task automatic test_abort;
      logic [31:0] r;
      logic [31:0] q;
      wr(OFS_PIN_SELECT, 32'hfffb);
      wr(OFS_PRELOAD, 32'h0);
      wr(OFS_CTRL0, 32'h20);
      repeat (20) @(posedge ref_clk);
      check(32'(refOscEn), 32'h1, "abort running");
      check(32'(keyOscEn), 32'h0, "key off without pin");
      rd(OFS_FUNC_LO, q);
      // Eight frozen edges: only the three edges of the first read may count
      ce <= 1'b0;
      repeat (8) @(posedge ref_clk);
      ce <= 1'b1;
      rd(OFS_FUNC_LO, r);
      check(r - q, 32'h3, "clock enable freeze");
      wr(OFS_CTRL0, 32'h0);
      // Stop takes effect one edge after the start bit is cleared
      @(posedge ref_clk);
      check(32'(refOscEn), 32'h0, "abort stops");
      rd(OFS_CTRL0, r);
      check(r, 32'h0, "no flag on abort");
      rd(OFS_FUNC_LO, r);
      check(r, 32'h0, "abort clears count");
      check({31'h0, irq}, 32'h0, "no irq on abort");
      $display("test_abort finished");
   endtask : test_abort

   // ------------------------------------------------------------
   // Sequence and timeout
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles >= LIMIT) begin
         errCount++;
         $display("unexpected at %0t: timeout", $time);
         endSim();
      end
   end

   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      test_regs();
      test_scan(8'hfe, 1'b1);
      test_scan(8'hf0, 1'b0);
      test_abort();
      endSim();
   end
endmodule : tb_touch_key_scan
